// ==== hw/ptu_defs.svh ====
// Register offsets, field positions, reset values and fixed counts of the time clock unit.
`ifndef PTU_DEFS_SVH
`define PTU_DEFS_SVH
`define PTU_REG_RATE_HI      5'h0A
`define PTU_REG_RATE_LO      5'h0B
`define PTU_REG_DUR_HI       5'h0C
`define PTU_REG_DUR_LO       5'h0D
`define PTU_REG_COC          5'h0E
`define PTU_REG_CTL          5'h10
`define PTU_REG_SEC_HI       5'h11
`define PTU_REG_SEC_LO       5'h12
`define PTU_REG_NS_HI        5'h13
`define PTU_REG_NS_LO        5'h14
`define PTU_REG_CLKSRC       5'h1B
`define PTU_REG_OFFSET       5'h1D
`define PTU_REG_PINMON       5'h1E
`define PTU_REG_HASH         5'h1F
`define PTU_CTL_LOAD         0
`define PTU_CTL_STEP         1
`define PTU_CTL_CAPTURE      2
`define PTU_RATE_NEG         15
`define PTU_RATE_TEMP        14
`define PTU_COC_EN           15
`define PTU_HASH_EN          12
`define PTU_SRC_INT          2'h0
`define PTU_SRC_DIV          2'h1
`define PTU_PER_MIN          7'h08
`define PTU_COC_DIV_MIN      8'h02
`define PTU_NS_PER_SEC       30'h3B9ACA00
`define PTU_PREAMBLE_LEN     6'h20
`define PTU_OP_READ          2'h2
`define PTU_OP_WRITE         2'h1
`define PTU_HDR_LAST         4'hB
`define PTU_DATA_LAST        4'hF
`define PTU_PHY_ADDR         5'h01
`endif

// ==== hw/ptu_pkg.sv ====
// Types shared by the time clock unit and its users.
package ptu_pkg;
  typedef enum logic [2:0] {
    PTU_MI_IDLE  = 3'b000,
    PTU_MI_START = 3'b001,
    PTU_MI_HDR   = 3'b010,
    PTU_MI_TA    = 3'b011,
    PTU_MI_DATA  = 3'b100
  } ptu_mi_state_t;

  typedef struct packed {
    logic        valid;
    logic        insert;
    logic [11:0] hash;
  } ptu_rx_evt_t;
endpackage

// ==== hw/ptu_time_clock_unit.sv ====
// Time clock unit: time keeping, rate steering, synchronized clock output and parser registers over MDIO.
`timescale 1ns/1ps
`include "ptu_defs.svh"
module ptu_time_clock_unit (
  input  wire logic               clock_i,
  input  wire logic               srst_i,
  input  wire logic               mdc_i,
  input  wire logic               mdio_i,
  output logic                    mdio_o,
  output logic                    mdio_oe_o,
  input  wire logic [11:0]        pin_input_levels_i,
  input  wire logic               ext_ref_i,
  input  wire logic [7:0]         message_byte_offset_i,
  input  wire ptu_pkg::ptu_rx_evt_t rx_evt_i,
  output logic                    rx_ts_deliver_o,
  output logic                    rx_ts_insert_o,
  output logic                    clk_out_o
);
  import ptu_pkg::*;

  // Pin synchronisers: the first stage is never read; logic reads the second, and a third MDC stage for edge detection.
  logic [11:0] pin_meta_r, pin_sync_r;
  logic [2:0]  mdc_meta_r, mdc_sync_r;
  logic        mdc_prev_r;
  always_ff @(posedge clock_i) begin
    pin_meta_r <= pin_input_levels_i;
    pin_sync_r <= pin_meta_r;
    mdc_meta_r <= {ext_ref_i, mdio_i, mdc_i};
    mdc_sync_r <= mdc_meta_r;
    mdc_prev_r <= mdc_sync_r[0];
  end
  logic mdc_rise, mdc_fall, mdio_s, ext_s;
  logic ext_prev_r;
  assign mdc_rise = mdc_sync_r[0] & ~mdc_prev_r;
  assign mdc_fall = ~mdc_sync_r[0] & mdc_prev_r;
  assign mdio_s   = mdc_sync_r[1];
  assign ext_s    = mdc_sync_r[2];

  // Register storage.
  logic [15:0] rate_hi_r, rate_lo_r, dur_hi_r, dur_lo_r, coc_r;
  logic [15:0] sec_hi_r, sec_lo_r, ns_hi_r, ns_lo_r, clksrc_r;
  logic [12:0] hash_r;
  logic [7:0]  offset_r;
  logic        cmd_load_r, cmd_step_r, cmd_cap_r, temp_start_r;
  logic [31:0] cap_sec_r;
  logic [29:0] cap_ns_r;

  // MDIO slave.
  ptu_mi_state_t mi_state_r;
  logic [5:0]  pre_cnt_r;
  logic [3:0]  bit_cnt_r;
  logic [11:0] hdr_r;
  logic [15:0] wsh_r, rsh_r;
  logic        rd_r, wr_r, wr_stb_r;
  logic [4:0]  wr_addr_r;
  logic [15:0] rd_data;

  always_comb begin
    case (hdr_r[4:0])
      `PTU_REG_RATE_HI: rd_data = rate_hi_r;
      `PTU_REG_RATE_LO: rd_data = rate_lo_r;
      `PTU_REG_DUR_HI:  rd_data = dur_hi_r;
      `PTU_REG_DUR_LO:  rd_data = dur_lo_r;
      `PTU_REG_COC:     rd_data = coc_r;
      `PTU_REG_SEC_HI:  rd_data = cap_sec_r[31:16];
      `PTU_REG_SEC_LO:  rd_data = cap_sec_r[15:0];
      `PTU_REG_NS_HI:   rd_data = {2'h0, cap_ns_r[29:16]};
      `PTU_REG_NS_LO:   rd_data = cap_ns_r[15:0];
      `PTU_REG_CLKSRC:  rd_data = clksrc_r;
      `PTU_REG_OFFSET:  rd_data = {8'h00, offset_r};
      `PTU_REG_PINMON:  rd_data = {4'h0, pin_sync_r};
      `PTU_REG_HASH:    rd_data = {3'h0, hash_r};
      default:          rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    wr_stb_r <= 1'b0;
    if (srst_i) begin
      mi_state_r <= PTU_MI_IDLE;
      pre_cnt_r  <= 6'h00;
      bit_cnt_r  <= 4'h0;
      hdr_r      <= 12'h000;
      wsh_r      <= 16'h0000;
      rd_r       <= 1'b0;
      wr_r       <= 1'b0;
      wr_addr_r  <= 5'h00;
    end else if (mdc_rise) begin
      case (mi_state_r)
        PTU_MI_IDLE: begin
          if (mdio_s) begin
            if (pre_cnt_r != `PTU_PREAMBLE_LEN) begin
              pre_cnt_r <= pre_cnt_r + 6'h01;
            end
          end else begin
            mi_state_r <= (pre_cnt_r == `PTU_PREAMBLE_LEN) ? PTU_MI_START : PTU_MI_IDLE;
            pre_cnt_r  <= 6'h00;
          end
        end
        PTU_MI_START: begin
          mi_state_r <= mdio_s ? PTU_MI_HDR : PTU_MI_IDLE;
          bit_cnt_r  <= 4'h0;
        end
        PTU_MI_HDR: begin
          hdr_r     <= {hdr_r[10:0], mdio_s};
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == `PTU_HDR_LAST) begin
            mi_state_r <= PTU_MI_TA;
            bit_cnt_r  <= 4'h0;
            rd_r <= (hdr_r[10:9] == `PTU_OP_READ) && (hdr_r[8:4] == `PTU_PHY_ADDR);
            wr_r <= (hdr_r[10:9] == `PTU_OP_WRITE) && (hdr_r[8:4] == `PTU_PHY_ADDR);
            wr_addr_r <= {hdr_r[3:0], mdio_s};
          end
        end
        PTU_MI_TA: begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r != 4'h0) begin
            mi_state_r <= PTU_MI_DATA;
            bit_cnt_r  <= 4'h0;
          end
        end
        PTU_MI_DATA: begin
          wsh_r     <= {wsh_r[14:0], mdio_s};
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == `PTU_DATA_LAST) begin
            mi_state_r <= PTU_MI_IDLE;
            wr_stb_r   <= wr_r;
            rd_r       <= 1'b0;
          end
        end
        default: mi_state_r <= PTU_MI_IDLE;
      endcase
    end
  end

  // Read data is driven on falling MDC, so it is stable at the master's rising-edge sample.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
      rsh_r     <= 16'h0000;
    end else if (mdc_fall) begin
      if (rd_r && mi_state_r == PTU_MI_TA && bit_cnt_r != 4'h0) begin
        mdio_o    <= 1'b0;
        mdio_oe_o <= 1'b1;
        rsh_r     <= rd_data;
      end else if (rd_r && mi_state_r == PTU_MI_DATA) begin
        mdio_o    <= rsh_r[15];
        mdio_oe_o <= 1'b1;
        rsh_r     <= {rsh_r[14:0], 1'b0};
      end else begin
        mdio_oe_o <= 1'b0;
        mdio_o    <= 1'b0;
      end
    end
  end

  // Register writes; reserved bits are never stored.
  always_ff @(posedge clock_i) begin
    cmd_load_r   <= 1'b0;
    cmd_step_r   <= 1'b0;
    cmd_cap_r    <= 1'b0;
    temp_start_r <= 1'b0;
    if (srst_i) begin
      rate_hi_r <= 16'h0000;
      rate_lo_r <= 16'h0000;
      dur_hi_r  <= 16'h0000;
      dur_lo_r  <= 16'h0000;
      coc_r     <= {8'h00, `PTU_COC_DIV_MIN};
      sec_hi_r  <= 16'h0000;
      sec_lo_r  <= 16'h0000;
      ns_hi_r   <= 16'h0000;
      ns_lo_r   <= 16'h0000;
      clksrc_r  <= {9'h000, `PTU_PER_MIN};
      hash_r    <= 13'h0000;
    end else if (wr_stb_r) begin
      case (wr_addr_r)
        `PTU_REG_RATE_HI: begin
          rate_hi_r    <= {wsh_r[15:14], 4'h0, wsh_r[9:0]};
          temp_start_r <= wsh_r[`PTU_RATE_TEMP];
        end
        `PTU_REG_RATE_LO: rate_lo_r <= wsh_r;
        `PTU_REG_DUR_HI:  dur_hi_r <= wsh_r;
        `PTU_REG_DUR_LO:  dur_lo_r <= wsh_r;
        `PTU_REG_COC: begin
          coc_r[15]  <= wsh_r[`PTU_COC_EN];
          coc_r[7:0] <= (wsh_r[7:0] < `PTU_COC_DIV_MIN) ? `PTU_COC_DIV_MIN : wsh_r[7:0];
        end
        `PTU_REG_CTL: begin
          cmd_load_r <= wsh_r[`PTU_CTL_LOAD];
          cmd_step_r <= wsh_r[`PTU_CTL_STEP];
          cmd_cap_r  <= wsh_r[`PTU_CTL_CAPTURE];
        end
        `PTU_REG_SEC_HI:  sec_hi_r <= wsh_r;
        `PTU_REG_SEC_LO:  sec_lo_r <= wsh_r;
        `PTU_REG_NS_HI:   ns_hi_r <= wsh_r;
        `PTU_REG_NS_LO:   ns_lo_r <= wsh_r;
        `PTU_REG_CLKSRC: begin
          clksrc_r[15:14] <= wsh_r[15:14];
          clksrc_r[6:0]   <= (wsh_r[6:0] < `PTU_PER_MIN) ? `PTU_PER_MIN : wsh_r[6:0];
        end
        `PTU_REG_HASH:    hash_r <= wsh_r[12:0];
        default: ;
      endcase
    end
  end

  // Parser-facing status and the receive hash filter.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      offset_r        <= 8'h00;
      rx_ts_deliver_o <= 1'b0;
      rx_ts_insert_o  <= 1'b0;
    end else begin
      offset_r        <= message_byte_offset_i;
      rx_ts_deliver_o <= rx_evt_i.valid &
                         (~hash_r[`PTU_HASH_EN] | (rx_evt_i.hash == hash_r[11:0]));
      rx_ts_insert_o  <= rx_evt_i.valid & rx_evt_i.insert;
    end
  end

  // Reference tick: every cycle, every N cycles, or each rising external edge.
  logic [3:0] div_cnt_r;
  logic       tick;
  logic [6:0] per_eff;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      div_cnt_r  <= 4'h0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_s;
      div_cnt_r  <= (div_cnt_r + 4'h1 >= clksrc_r[6:3]) ? 4'h0 : div_cnt_r + 4'h1;
    end
  end
  always_comb begin
    case (clksrc_r[15:14])
      `PTU_SRC_INT: begin
        tick    = 1'b1;
        per_eff = clksrc_r[6:0];
      end
      `PTU_SRC_DIV: begin
        tick    = (div_cnt_r == 4'h0);
        per_eff = {clksrc_r[6:3], 3'h0};
      end
      default: begin
        tick    = ext_s & ~ext_prev_r;
        per_eff = clksrc_r[6:0];
      end
    endcase
  end

  // Rate correction, permanent or for a counted number of ticks.
  logic [31:0] temp_cnt_r;
  logic        rate_on;
  logic [63:0] inc;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      temp_cnt_r <= 32'h0000_0000;
    end else if (temp_start_r) begin
      temp_cnt_r <= {dur_hi_r, dur_lo_r};
    end else if (tick && temp_cnt_r != 32'h0000_0000) begin
      temp_cnt_r <= temp_cnt_r - 32'h0000_0001;
    end
  end
  assign rate_on = ~rate_hi_r[`PTU_RATE_TEMP] | (temp_cnt_r != 32'h0000_0000);
  always_comb begin
    inc = {25'h0000000, per_eff, 32'h0000_0000};
    if (rate_on) begin
      if (rate_hi_r[`PTU_RATE_NEG]) begin
        inc = inc - {38'h0, rate_hi_r[9:0], rate_lo_r};
      end else begin
        inc = inc + {38'h0, rate_hi_r[9:0], rate_lo_r};
      end
    end
  end

  // Time value; only 32 seconds bits exist, the upper protocol bits are left to software.
  logic [31:0] sec_r, sec_nxt;
  logic [29:0] ns_r, ns_nxt;
  logic [31:0] frac_r, frac_nxt;
  logic [63:0] acc_sum;
  logic signed [33:0] step_ns;
  logic signed [32:0] step_sec;
  always_comb begin
    sec_nxt  = sec_r;
    ns_nxt   = ns_r;
    frac_nxt = frac_r;
    step_ns  = $signed({4'h0, ns_r}) + $signed({{2{ns_hi_r[15]}}, ns_hi_r, ns_lo_r});
    step_sec = $signed({1'b0, sec_r});
    acc_sum  = {2'h0, ns_r, frac_r} + inc;
    // Three passes cover the largest step, a little over two seconds either way.
    for (int i = 0; i < 3; i++) begin
      if (step_ns < 0) begin
        step_ns  = step_ns + $signed({4'h0, `PTU_NS_PER_SEC});
        step_sec = step_sec - 33'sd1;
      end else if (step_ns >= $signed({4'h0, `PTU_NS_PER_SEC})) begin
        step_ns  = step_ns - $signed({4'h0, `PTU_NS_PER_SEC});
        step_sec = step_sec + 33'sd1;
      end
    end
    if (cmd_load_r) begin
      sec_nxt = {sec_hi_r, sec_lo_r};
      ns_nxt  = {ns_hi_r[13:0], ns_lo_r};
      frac_nxt = 32'h0000_0000;
    end else if (cmd_step_r) begin
      // A tick landing on the step cycle is dropped; the error is one tick increment, about one period.
      if (step_sec < 0) begin
        sec_nxt  = 32'h0000_0000;
        ns_nxt   = 30'h00000000;
        frac_nxt = 32'h0000_0000;
      end else begin
        sec_nxt = step_sec[31:0];
        ns_nxt  = step_ns[29:0];
      end
    end else if (tick) begin
      frac_nxt = acc_sum[31:0];
      if (acc_sum[63:32] >= {2'h0, `PTU_NS_PER_SEC}) begin
        ns_nxt  = 30'(acc_sum[63:32] - {2'h0, `PTU_NS_PER_SEC});
        sec_nxt = sec_r + 32'h0000_0001;
      end else begin
        ns_nxt = acc_sum[61:32];
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sec_r  <= 32'h0000_0000;
      ns_r   <= 30'h00000000;
      frac_r <= 32'h0000_0000;
    end else begin
      sec_r  <= sec_nxt;
      ns_r   <= ns_nxt;
      frac_r <= frac_nxt;
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cap_sec_r <= 32'h0000_0000;
      cap_ns_r  <= 30'h00000000;
    end else if (cmd_cap_r) begin
      cap_sec_r <= sec_r;
      cap_ns_r  <= ns_r;
    end
  end

  // Output clock: a phase accumulator on the same increment, so rate steering is followed but steps
  // are not. Half period is divisor times 2 ns; increments above a half period lose edges.
  logic [40:0] phase_r, phase_sum;
  logic [40:0] half_per;
  assign half_per  = {coc_r[7:0], 1'b0, 32'h0000_0000};
  assign phase_sum = phase_r + {inc[40:0]};
  always_ff @(posedge clock_i) begin
    if (srst_i || !coc_r[`PTU_COC_EN]) begin
      phase_r   <= 41'h000_0000_0000;
      clk_out_o <= 1'b0;
    end else if (tick) begin
      if (phase_sum >= half_per) begin
        phase_r   <= phase_sum - half_per;
        clk_out_o <= ~clk_out_o;
      end else begin
        phase_r <= phase_sum;
      end
    end
  end
endmodule

// ==== verif/ptu_time_clock_unit_sva.sv ====
// Port-level assertions and covers for the time clock unit.
`timescale 1ns/1ps
module ptu_time_clock_unit_sva (
  input wire logic                 clock_i,
  input wire logic                 srst_i,
  input wire logic                 mdc_i,
  input wire logic                 mdio_o,
  input wire logic                 mdio_oe_o,
  input wire ptu_pkg::ptu_rx_evt_t rx_evt_i,
  input wire logic                 rx_ts_deliver_o,
  input wire logic                 rx_ts_insert_o,
  input wire logic                 clk_out_o
);
  import ptu_pkg::*;
  logic [15:0] oe_cnt_r;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  always_ff @(posedge clock_i) begin
    oe_cnt_r <= mdio_oe_o ? oe_cnt_r + 16'h0001 : 16'h0000;
  end
  property p_ins_on; rx_evt_i.valid && rx_evt_i.insert |=> rx_ts_insert_o; endproperty
  a_ins_on: assert property (p_ins_on) else $error("insert pulse missing");
  property p_ins_off; !(rx_evt_i.valid && rx_evt_i.insert) |=> !rx_ts_insert_o; endproperty
  a_ins_off: assert property (p_ins_off) else $error("insert pulse without cause");
  property p_dlv_idle; !rx_evt_i.valid |=> !rx_ts_deliver_o; endproperty
  a_dlv_idle: assert property (p_dlv_idle) else $error("deliver pulse without event");
  property p_oe_rise; $rose(mdio_oe_o) |-> !mdc_i && !mdio_o; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("read turnaround not driven low");
  property p_oe_fall; $fell(mdio_oe_o) |-> !mdc_i; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("read drive dropped off the falling edge");
  // Seventeen MDC periods at the fastest legal MDC rate.
  property p_oe_len; $fell(mdio_oe_o) |-> oe_cnt_r >= 16'h0088; endproperty
  a_oe_len: assert property (p_oe_len) else $error("read drive too short");
  property p_oe_hold; $rose(mdio_oe_o) |-> mdio_oe_o [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("read drive glitch");
  property p_data_edge; mdio_oe_o && $past(mdio_oe_o) && $changed(mdio_o) |-> !mdc_i; endproperty
  a_data_edge: assert property (p_data_edge) else $error("read data moved while MDC high");
  c_ins: cover property (rx_evt_i.valid && rx_evt_i.insert);
  c_dlv: cover property (rx_ts_deliver_o);
  c_read: cover property ($rose(mdio_oe_o));
  c_clk: cover property ($rose(clk_out_o));
endmodule
bind ptu_time_clock_unit ptu_time_clock_unit_sva sva (.clock_i(clock_i), .srst_i(srst_i), .mdc_i(mdc_i),
  .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .rx_evt_i(rx_evt_i), .rx_ts_deliver_o(rx_ts_deliver_o),
  .rx_ts_insert_o(rx_ts_insert_o), .clk_out_o(clk_out_o));

// ==== verif/ptu_mdio_host.sv ====
// Management host model: clocks frames into the unit and samples read data.
`timescale 1ns/1ps
`include "ptu_defs.svh"
module ptu_mdio_host (
  input  wire logic clock_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_d_o,
  output logic      mdio_oe_o
);
  initial begin
    mdc_o = 1'b0;
    mdio_d_o = 1'b0;
    mdio_oe_o = 1'b0;
  end
  task automatic half();
    repeat (6) @(posedge clock_i);
    #1;
  endtask
  // Every frame repeats the preamble; MDC rests low and the line is released between frames.
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] b;
    b = {32'hFFFFFFFF, 2'b01, op, `PTU_PHY_ADDR, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      mdio_oe_o = op == `PTU_OP_WRITE || i > 17;
      mdio_d_o = b[i];
      half();
      mdc_o = 1'b1;
      if (i < 16) rd[i] = mdio_i;
      half();
      mdc_o = 1'b0;
    end
    mdio_oe_o = 1'b0;
    half();
  endtask
endmodule

// ==== verif/ptu_time_clock_unit_bench.sv ====
// Self-checking bench of the time clock unit driven through the management host model.
`timescale 1ns/1ps
`include "ptu_defs.svh"
module ptu_time_clock_unit_bench;
  import ptu_pkg::*;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [11:0] pins = 12'h000;
  logic [7:0]  offs = 8'h00;
  ptu_rx_evt_t evt = '0;
  logic        mdc, h_d, h_oe, d_o, d_oe, dlv, ins, cko, mdio_w, pv;
  logic [15:0] hv, hr;
  logic [31:0] s, n, t0, t1, d0;
  integer      seed = 32'hAC20;
  integer      n_mismatch = 0;
  integer      n_checks = 0;
  integer      cyc = 0;
  integer      tg;
  always #5 clock_i = ~clock_i;
  // The line has a pull-up, so it reads high whenever nobody drives it.
  assign mdio_w = d_oe ? d_o : (h_oe ? h_d : 1'b1);
  ptu_time_clock_unit uut (.clock_i(clock_i), .srst_i(srst_i), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(d_o),
    .mdio_oe_o(d_oe), .pin_input_levels_i(pins), .ext_ref_i(1'b0), .message_byte_offset_i(offs),
    .rx_evt_i(evt), .rx_ts_deliver_o(dlv), .rx_ts_insert_o(ins), .clk_out_o(cko));
  ptu_mdio_host host (.clock_i(clock_i), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_d_o(h_d), .mdio_oe_o(h_oe));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    host.frame(`PTU_OP_WRITE, a, d, hv);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    host.frame(`PTU_OP_READ, a, 16'h0000, hv);
    chk($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, hv});
  endtask
  task automatic setw(input logic [31:0] sv, input logic [31:0] nv, input int c);
    if (c == `PTU_CTL_LOAD) begin
      wr(`PTU_REG_SEC_HI, sv[31:16]);
      wr(`PTU_REG_SEC_LO, sv[15:0]);
    end
    wr(`PTU_REG_NS_HI, nv[31:16]);
    wr(`PTU_REG_NS_LO, nv[15:0]);
    wr(`PTU_REG_CTL, 16'(1 << c));
  endtask
  task automatic capt();
    logic [15:0] q [4];
    wr(`PTU_REG_CTL, 16'(1 << `PTU_CTL_CAPTURE));
    for (int i = 0; i < 4; i++) host.frame(`PTU_OP_READ, 5'(`PTU_REG_SEC_HI + i), 16'h0000, q[i]);
    s = {q[0], q[1]};
    n = {q[2], q[3]};
  endtask
  function automatic logic exp_dlv(input ptu_rx_evt_t e, input logic [15:0] h);
    return e.valid && (!h[`PTU_HASH_EN] || e.hash == h[11:0]);
  endfunction
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 98000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clock_i);
    #1 srst_i = 1'b0;
    rdc(`PTU_REG_COC, 16'h0002);
    rdc(`PTU_REG_CLKSRC, 16'h0008);
    rdc(`PTU_REG_HASH, 16'h0000);
    $display("test reset values done");
    repeat (2) begin
      offs = 8'($random(seed));
      pins = 12'($random(seed));
      wr(`PTU_REG_OFFSET, 16'hFFFF);
      rdc(`PTU_REG_OFFSET, {8'h00, offs});
      rdc(`PTU_REG_PINMON, {4'h0, pins});
    end
    $display("test monitors done");
    for (int m = 0; m < 2; m++) begin
      hr = 16'($random(seed));
      hr[`PTU_HASH_EN] = m[0];
      wr(`PTU_REG_HASH, hr);
      rdc(`PTU_REG_HASH, hr & 16'h1FFF);
      pv = 1'b0;
      repeat (300) begin
        evt = 14'($random(seed));
        evt.valid = evt.valid & ~pv;
        if (evt.hash[0]) evt.hash = hr[11:0];
        pv = evt.valid;
        @(posedge clock_i);
        #1;
        chk("deliver", 32'(exp_dlv(evt, hr)), 32'(dlv));
        chk("insert", 32'(evt.valid & evt.insert), 32'(ins));
      end
      evt = '0;
    end
    $display("test hash filter done");
    wr(`PTU_REG_CLKSRC, 16'h0003);
    rdc(`PTU_REG_CLKSRC, 16'h0008);
    wr(`PTU_REG_CLKSRC, 16'hFFFF);
    rdc(`PTU_REG_CLKSRC, 16'hC07F);
    // The external reference stays still here, so time is frozen and exact.
    setw(32'h0000_0001, 32'h1234_5678, `PTU_CTL_LOAD);
    setw(32'h0, 32'hFFFF_FFF6, `PTU_CTL_STEP);
    capt();
    chk("seconds", 32'h0000_0001, s);
    chk("nanoseconds", 32'h1234_566E, n);
    setw(32'h0, 32'h8000_0000, `PTU_CTL_STEP);
    capt();
    chk("clamped time", 32'h0, s | n);
    wr(`PTU_REG_CLKSRC, 16'h4010);
    setw(32'hFFFF_FFFF, 32'h3B9A_C99C, `PTU_CTL_LOAD);
    capt();
    chk("wrapped seconds", 32'h0, s);
    chk("ns window", 32'h1, 32'(n < 32'h4E20));
    $display("test time set and step done");
    wr(`PTU_REG_CLKSRC, 16'h0008);
    // Runs 3 and 4 are temporary: a short duration that has run out, then one that outlasts both captures.
    for (int r = 0; r < 5; r++) begin
      if (r > 2) begin
        wr(`PTU_REG_DUR_HI, r == 3 ? 16'h0000 : 16'h0001);
        wr(`PTU_REG_DUR_LO, 16'h0100);
        wr(`PTU_REG_RATE_HI, 16'h43FF);
      end else if (r > 0) begin
        wr(`PTU_REG_RATE_HI, r == 1 ? 16'h03FF : 16'h83FF);
        wr(`PTU_REG_RATE_LO, 16'hFFFF);
      end
      capt();
      t0 = n;
      capt();
      t1 = n - t0;
      if (r == 0) d0 = t1;
      else if (r == 3) chk("expired temporary rate", d0, t1);
      else chk("rate", 32'h1, 32'(r == 2 ? t1 + 32'h28 < d0 : t1 > d0 + 32'h28));
    end
    $display("test rate done");
    wr(`PTU_REG_COC, 16'h8001);
    rdc(`PTU_REG_COC, 16'h8002);
    wr(`PTU_REG_COC, 16'h8010);
    tg = 0;
    pv = cko;
    repeat (400) begin
      @(posedge clock_i);
      #1;
      tg += (cko != pv);
      pv = cko;
    end
    chk("output clock toggles", 32'h1, 32'(tg > 90 && tg < 110));
    $display("test output clock done");
    print_verdict();
  end
endmodule
